// ---- mas_pkg.sv ----
//
// Purpose : shared constants for the measurement converter scheduler
// Assumes : 200 MHz core clock, 8-bit control register port
// Notes   : rates are kept in hertz, thermal in millihertz, cycle counts derive from them
//
`default_nettype none

package mas_pkg;

   // ****************************************************************
   // register map and field layout
   // ****************************************************************
   localparam logic [15:0] MAS_PEAK_HIGH_ADDR  = 16'h20c5; // peak_temp_code_high
   localparam logic [15:0] MAS_PEAK_LOW_ADDR   = 16'h20c6; // peak_temp_low_bit
   localparam logic [15:0] MAS_RATE_PLAN_ADDR  = 16'h20c7; // adc_rate_plan
   localparam logic [15:0] MAS_CH_FORCE_ADDR   = 16'h20c8; // adc_channel_force
   localparam logic [15:0] MAS_PIVOT_ADDR      = 16'h20d0; // compressor_pivot_point

   localparam int          MAS_PLAN_MODE_LSB   = 0;        // optimal_rate_plan [1:0]
   localparam int          MAS_PLAN_AVG_LSB    = 2;        // optimized_average_depth [3:2]
   localparam int          MAS_FORCE_POWER_BIT = 0;        // power_rail_channel_force
   localparam int          MAS_FORCE_BATT_BIT  = 1;        // battery rail force
   localparam int          MAS_FORCE_HIGH_BIT  = 2;        // high_rail_channel_force

   localparam logic [1:0]  MAS_MODE_RESET      = 2'h0;
   localparam logic [1:0]  MAS_AVG_RESET       = 2'h1;
   localparam logic [2:0]  MAS_FORCE_RESET     = 3'h0;
   localparam logic [3:0]  MAS_PIVOT_RESET     = 4'h0;
   localparam logic [8:0]  MAS_PEAK_RESET      = 9'h000;
   localparam logic [7:0]  MAS_RDATA_UNMAPPED  = 8'h00;

   // ****************************************************************
   // conversions
   // ****************************************************************
   localparam logic [9:0]  MAS_TEMP_OFFSET_C   = 10'h0fc;  // 252 degrees below the code
   localparam logic [3:0]  MAS_PIVOT_LAST_CODE = 4'ha;     // above this reserved
   localparam logic [3:0]  MAS_PIVOT_STEP_LAST = 4'h6;     // 1 dB steps up to here

   // ****************************************************************
   // sampling rates and derived periods (rounded down)
   // ****************************************************************
   localparam int          MAS_CLK_HZ          = 200_000_000;
   localparam int          MAS_OPT1_SRC_HZ     = 600_000;
   localparam int          MAS_OPT1_SEC_HZ     = 300_000;
   localparam int          MAS_OPT2_SRC_HZ     = 900_000;
   localparam int          MAS_OPT2_SEC_HZ     = 75_000;
   localparam int          MAS_OPT_THERM_MHZ   = 37_500_000; // 37.5 kHz in millihertz
   localparam int          MAS_PER_W           = 16;
   localparam logic [15:0] MAS_OPT1_SRC_CYC    = 16'(MAS_CLK_HZ / MAS_OPT1_SRC_HZ);
   localparam logic [15:0] MAS_OPT1_SEC_CYC    = 16'(MAS_CLK_HZ / MAS_OPT1_SEC_HZ);
   localparam logic [15:0] MAS_OPT2_SRC_CYC    = 16'(MAS_CLK_HZ / MAS_OPT2_SRC_HZ);
   localparam logic [15:0] MAS_OPT2_SEC_CYC    = 16'(MAS_CLK_HZ / MAS_OPT2_SEC_HZ);
   localparam logic [15:0] MAS_OPT_THERM_CYC   =
      16'((64'(MAS_CLK_HZ) * 64'd1000) / 64'(MAS_OPT_THERM_MHZ));

   // ****************************************************************
   // mode encodings
   // ****************************************************************
   typedef enum logic [1:0] {
      MAS_REGULAR  = 2'b00,
      MAS_OPTIMAL1 = 2'b01,
      MAS_OPTIMAL2 = 2'b10,
      MAS_MODE_RSV = 2'b11
   } mas_mode_type;

   typedef enum logic [1:0] {
      MAS_AVG_BYPASS = 2'b00,
      MAS_AVG_TWO    = 2'b01,
      MAS_AVG_FOUR   = 2'b10,
      MAS_AVG_RSV    = 2'b11
   } mas_avg_type;

endpackage : mas_pkg

`default_nettype wire

// ---- mas_rate_div.sv ----
//
// Purpose : programmable divider giving a one-cycle sample enable
// Assumes : period counted in core clock cycles, zero treated as one
// Notes   : a new period takes effect at the next reload
//
`timescale 1ns/1ps
`default_nettype none

module mas_rate_div #(
   parameter int W = 16                    // period counter width
) (
   input  wire logic         clk,          // core clock
   input  wire logic         rstn,         // async reset, active low
   input  wire logic         run,          // divider runs while high
   input  wire logic [W-1:0] period,       // cycles between ticks
   output logic              tick          // one-cycle enable pulse
);

   logic [W-1:0] count_r;
   logic [W-1:0] count_nxt;
   logic         tick_nxt;
   logic [W-1:0] reload;

   // reload value, guarding against a zero period
   assign reload    = (period == '0) ? '0 : period - W'(1);
   assign tick_nxt  = run && (count_r == '0);
   assign count_nxt = !run ? '0 : ((count_r == '0) ? reload : count_r - W'(1));

   // ****************************************************************
   // counter
   // ****************************************************************
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         count_r <= '0;
         tick    <= 1'b0;
      end else begin
         count_r <= count_nxt;
         tick    <= tick_nxt;
      end
   end

endmodule : mas_rate_div

`default_nettype wire

// ---- mas_scheduler.sv ----
//
// Purpose : control and readback for the measurement converter scheduler
// Assumes : single core clock, register port synchronous to it
// Notes   : strobes index 0 power rail, 1 battery rail, 2 high rail, 3 thermal
//
// Overview of operation
// R1: Peak temperature is a 9-bit code; Celsius equals code minus 252.
// R2: Code bits 8 to 1 read from the high register, reset zero.
// R3: Averaging field picks bypass, two or four samples in optimal mode.
// R4: Mode code 0 runs the converter at regular per-channel rates.
// R5: Optimal mode: brownout source fastest, other rail medium, thermal fixed.
// R6: Mode 1: source 600 kHz, other rail 300 kHz, thermal 37.5 kHz.
// R7: Mode 2: source 900 kHz, other rail 75 kHz, thermal 37.5 kHz.
// R8: Optimal modes ignore the per-channel rate settings; the high rail still uses HIGH_RATE_CYC.
// R9: Bit 2 forces the high-rail channel on while active.
// R10: Bit 1 forces the battery-rail channel on while active.
// R11: Bit 0 forces the power-rail channel on while active.
// R12: A clear force bit still allows automatic channel enable.
// R13: Pivot codes 0-6 give 0 to -6 dB, 7-10 give -8,-10,-12,-15.
// R14: Reserved mode and average codes act as regular mode and bypass.
// R15: Writable fields read back as written; unused bits read zero.
//
`timescale 1ns/1ps
`default_nettype none

module mas_scheduler
#(
   parameter logic [15:0] THERM_OPT_CYC = mas_pkg::MAS_OPT_THERM_CYC // fixed thermal period
) (
   input  wire logic        CORE_CLK,                 // core clock 200 MHz
   input  wire logic        RSTN,                     // async reset, active low
   input  wire logic [15:0] REG_ADDR,                 // register address
   input  wire logic        REG_WR,                   // write strobe
   input  wire logic        REG_RD,                   // read strobe
   input  wire logic [7:0]  REG_WDATA,                // write data
   output logic      [7:0]  REG_RDATA,                // read data, next cycle
   input  wire logic        ACTIVE,                   // device in active state
   input  wire logic        BROWNOUT_SOURCE_SELECT,   // 0 power rail, 1 battery rail
   input  wire logic [2:0]  CH_AUTO_REQ,              // internal channel requests
   input  wire logic [15:0] POWER_RATE_CYC,           // regular power rail period
   input  wire logic [15:0] BATTERY_RATE_CYC,         // regular battery rail period
   input  wire logic [15:0] HIGH_RATE_CYC,            // regular high rail period
   input  wire logic [15:0] THERM_RATE_CYC,           // regular thermal period
   input  wire logic [8:0]  TEMP_CODE,                // new thermal code
   input  wire logic        TEMP_CODE_VALID,          // thermal code strobe
   input  wire logic [8:0]  SRC_SAMPLE,               // brownout source sample
   input  wire logic        SRC_SAMPLE_VALID,         // source sample strobe
   output logic      [2:0]  CH_ENABLE,                // channel enables
   output logic      [3:0]  SAMPLE_STROBE,            // per-channel sample enables
   output logic      [9:0]  PEAK_TEMP_C,              // peak temperature, signed C
   output logic      [8:0]  SRC_AVG,                  // averaged source sample
   output logic             SRC_AVG_VALID,            // average strobe
   output logic      [3:0]  PIVOT_ATTEN_DB,           // pivot attenuation in dB
   output logic             PIVOT_RESERVED,           // pivot code reserved
   output logic             OPT_MODE_ACTIVE           // an optimal mode in force
);

   import mas_pkg::*;

   // ****************************************************************
   // register state
   // ****************************************************************
   logic [1:0]   plan_mode_r, plan_avg_r;
   logic [2:0]   force_r;
   logic [3:0]   pivot_r;
   logic [8:0]   peak_r, peak_nxt;

   // address decode
   logic         hit_high, hit_low, hit_plan, hit_force, hit_pivot;
   logic [7:0]   rdata_nxt;

   assign hit_high  = (REG_ADDR == MAS_PEAK_HIGH_ADDR);
   assign hit_low   = (REG_ADDR == MAS_PEAK_LOW_ADDR);
   assign hit_plan  = (REG_ADDR == MAS_RATE_PLAN_ADDR);
   assign hit_force = (REG_ADDR == MAS_CH_FORCE_ADDR);
   assign hit_pivot = (REG_ADDR == MAS_PIVOT_ADDR);

   // R2 R15: readback, unused bits zero
   assign rdata_nxt = hit_high  ? peak_r[8:1] :
                      hit_low   ? {7'h00, peak_r[0]} :
                      hit_plan  ? {4'h0, plan_avg_r, plan_mode_r} :
                      hit_force ? {5'h00, force_r} :
                      hit_pivot ? {4'h0, pivot_r} :
                                  MAS_RDATA_UNMAPPED;

   // writable fields, stored exactly as written
   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         plan_mode_r <= MAS_MODE_RESET;
         plan_avg_r  <= MAS_AVG_RESET;
         force_r     <= MAS_FORCE_RESET;
         pivot_r     <= MAS_PIVOT_RESET;
      end else if (REG_WR) begin
         if (hit_plan) begin
            plan_mode_r <= REG_WDATA[MAS_PLAN_MODE_LSB +: 2];
            plan_avg_r  <= REG_WDATA[MAS_PLAN_AVG_LSB +: 2];
         end else if (hit_force) begin
            force_r <= REG_WDATA[2:0];
         end else if (hit_pivot) begin
            pivot_r <= REG_WDATA[3:0];
         end
      end
   end

   // read data, held until the next read
   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         REG_RDATA <= MAS_RDATA_UNMAPPED;
      end else if (REG_RD) begin
         REG_RDATA <= rdata_nxt;
      end
   end

   // ****************************************************************
   // peak temperature tracking
   // ****************************************************************
   // R1: peak code kept
   assign peak_nxt = (TEMP_CODE_VALID && (TEMP_CODE > peak_r)) ? TEMP_CODE : peak_r;

   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         peak_r      <= MAS_PEAK_RESET;
         PEAK_TEMP_C <= 10'h000 - MAS_TEMP_OFFSET_C;
      end else begin
         peak_r      <= peak_nxt;
         // R1: code minus 252
         PEAK_TEMP_C <= {1'b0, peak_nxt} - MAS_TEMP_OFFSET_C;
      end
   end

   // ****************************************************************
   // rate plan selection
   // ****************************************************************
   mas_mode_type mode;
   mas_avg_type  avg;
   logic         opt_on;
   logic [15:0]  src_opt_cyc, sec_opt_cyc;
   logic [15:0]  power_cyc, battery_cyc, therm_cyc;

   assign mode = mas_mode_type'(plan_mode_r);
   assign avg  = mas_avg_type'(plan_avg_r);

   // R4 R14: code 0 and reserved code regular
   assign opt_on = (mode == MAS_OPTIMAL1) || (mode == MAS_OPTIMAL2);

   // R6 R7: mode 1 and 2 rates
   assign src_opt_cyc = (mode == MAS_OPTIMAL2) ? MAS_OPT2_SRC_CYC : MAS_OPT1_SRC_CYC;
   assign sec_opt_cyc = (mode == MAS_OPTIMAL2) ? MAS_OPT2_SEC_CYC : MAS_OPT1_SEC_CYC;

   // R5 R8: source fastest, rates ignored
   assign power_cyc   = !opt_on ? POWER_RATE_CYC :
                        (BROWNOUT_SOURCE_SELECT ? sec_opt_cyc : src_opt_cyc);
   assign battery_cyc = !opt_on ? BATTERY_RATE_CYC :
                        (BROWNOUT_SOURCE_SELECT ? src_opt_cyc : sec_opt_cyc);
   assign therm_cyc   = opt_on ? THERM_OPT_CYC : THERM_RATE_CYC;

   // ****************************************************************
   // channel enables and sample dividers
   // ****************************************************************
   logic [2:0] ch_en_nxt;
   logic [3:0] ticks, strobe_nxt;

   // R9 R10 R11 R12: force or automatic enable
   assign ch_en_nxt = {3{ACTIVE}} & (force_r | CH_AUTO_REQ);

   mas_rate_div #(.W(MAS_PER_W)) u_div_power (
      .clk    (CORE_CLK),  .rstn   (RSTN),
      .run    (CH_ENABLE[MAS_FORCE_POWER_BIT]),
      .period (power_cyc),
      .tick   (ticks[0])
   );

   mas_rate_div #(.W(MAS_PER_W)) u_div_battery (
      .clk    (CORE_CLK),  .rstn   (RSTN),
      .run    (CH_ENABLE[MAS_FORCE_BATT_BIT]),
      .period (battery_cyc),
      .tick   (ticks[1])
   );

   mas_rate_div #(.W(MAS_PER_W)) u_div_high (
      .clk    (CORE_CLK),  .rstn   (RSTN),
      .run    (CH_ENABLE[MAS_FORCE_HIGH_BIT]),
      .period (HIGH_RATE_CYC),
      .tick   (ticks[2])
   );

   mas_rate_div #(.W(MAS_PER_W)) u_div_therm (
      .clk    (CORE_CLK),  .rstn   (RSTN),
      .run    (ACTIVE),
      .period (therm_cyc),
      .tick   (ticks[3])
   );

   // strobes only while the channel is still enabled
   assign strobe_nxt = ticks & {ACTIVE, CH_ENABLE};

   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         CH_ENABLE       <= 3'h0;
         SAMPLE_STROBE   <= 4'h0;
         OPT_MODE_ACTIVE <= 1'b0;
      end else begin
         CH_ENABLE       <= ch_en_nxt;
         SAMPLE_STROBE   <= strobe_nxt;
         OPT_MODE_ACTIVE <= opt_on;
      end
   end

   // ****************************************************************
   // moving average of the optimized channel
   // ****************************************************************
   logic [8:0]  hist_r [3];
   logic [10:0] sum_two, sum_four;
   logic [8:0]  avg_nxt;

   assign sum_two  = 11'(SRC_SAMPLE) + 11'(hist_r[0]);
   assign sum_four = sum_two + 11'(hist_r[1]) + 11'(hist_r[2]);

   // R3 R14: depth select, reserved bypasses
   assign avg_nxt = !opt_on              ? SRC_SAMPLE :
                    (avg == MAS_AVG_TWO)  ? sum_two[9:1] :
                    (avg == MAS_AVG_FOUR) ? sum_four[10:2] :
                                            SRC_SAMPLE;

   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         hist_r[0]     <= 9'h000;
         hist_r[1]     <= 9'h000;
         hist_r[2]     <= 9'h000;
         SRC_AVG       <= 9'h000;
         SRC_AVG_VALID <= 1'b0;
      end else begin
         SRC_AVG_VALID <= SRC_SAMPLE_VALID;
         if (SRC_SAMPLE_VALID) begin
            hist_r[0] <= SRC_SAMPLE;
            hist_r[1] <= hist_r[0];
            hist_r[2] <= hist_r[1];
            SRC_AVG   <= avg_nxt;
         end
      end
   end

   // ****************************************************************
   // compressor pivot decode
   // ****************************************************************
   logic [3:0] pivot_db_nxt;
   logic       pivot_rsv_nxt;

   // R13: pivot mapping
   assign pivot_rsv_nxt = (pivot_r > MAS_PIVOT_LAST_CODE);
   assign pivot_db_nxt  = (pivot_r <= MAS_PIVOT_STEP_LAST) ? pivot_r :
                          (pivot_r == 4'h7) ? 4'h8 :
                          (pivot_r == 4'h8) ? 4'ha :
                          (pivot_r == 4'h9) ? 4'hc :
                          (pivot_r == 4'ha) ? 4'hf : 4'h0;

   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         PIVOT_ATTEN_DB <= 4'h0;
         PIVOT_RESERVED <= 1'b0;
      end else begin
         PIVOT_ATTEN_DB <= pivot_db_nxt;
         PIVOT_RESERVED <= pivot_rsv_nxt;
      end
   end

   // ****************************************************************
   // assertions
   // ****************************************************************
   sequence s_plan_write;
      REG_WR && hit_plan;
   endsequence
   sequence s_plan_read;
      REG_RD && hit_plan && !REG_WR;
   endsequence
   property p_temp_conv;
      @(posedge CORE_CLK) disable iff (!RSTN)
      ##1 PEAK_TEMP_C == 10'({1'b0, peak_r} - 10'd252);
   endproperty
   a_temp_conv: assert property (p_temp_conv) else $error("peak temp conversion"); // R1
   property p_peak_high;
      @(posedge CORE_CLK) disable iff (!RSTN)
      (REG_RD && hit_high) |=> REG_RDATA == $past(peak_r[8:1]);
   endproperty
   a_peak_high: assert property (p_peak_high) else $error("peak high readback"); // R2
   property p_avg_two;
      @(posedge CORE_CLK) disable iff (!RSTN)
      (SRC_SAMPLE_VALID && opt_on && avg == MAS_AVG_TWO)
         |=> SRC_AVG == 9'((11'($past(SRC_SAMPLE)) + 11'($past(hist_r[0]))) >> 1);
   endproperty
   a_avg_two: assert property (p_avg_two) else $error("two-sample average"); // R3
   property p_regular;
      @(posedge CORE_CLK) disable iff (!RSTN)
      (plan_mode_r == 2'h0) |-> power_cyc == POWER_RATE_CYC && therm_cyc == THERM_RATE_CYC;
   endproperty
   a_regular: assert property (p_regular) else $error("regular rates not used"); // R4
   property p_opt1;
      @(posedge CORE_CLK) disable iff (!RSTN)
      (plan_mode_r == 2'h1 && !BROWNOUT_SOURCE_SELECT)
         |-> power_cyc == 16'd333 && battery_cyc == 16'd666 && therm_cyc == THERM_OPT_CYC;
   endproperty
   a_opt1: assert property (p_opt1) else $error("optimal mode 1 periods"); // R6
   property p_opt2;
      @(posedge CORE_CLK) disable iff (!RSTN)
      (plan_mode_r == 2'h2 && !BROWNOUT_SOURCE_SELECT)
         |-> power_cyc == 16'd222 && battery_cyc == 16'd2666;
   endproperty
   a_opt2: assert property (p_opt2) else $error("optimal mode 2 periods"); // R7
   property p_force_high;
      @(posedge CORE_CLK) disable iff (!RSTN)
      (ACTIVE && force_r[2]) |=> CH_ENABLE[2];
   endproperty
   a_force_high: assert property (p_force_high) else $error("high rail not forced"); // R9
   property p_auto_kept;
      @(posedge CORE_CLK) disable iff (!RSTN)
      (ACTIVE && !force_r[0] && CH_AUTO_REQ[0]) |=> CH_ENABLE[0];
   endproperty
   a_auto_kept: assert property (p_auto_kept) else $error("auto enable blocked"); // R12
   property p_pivot;
      @(posedge CORE_CLK) disable iff (!RSTN)
      (pivot_r == 4'ha) |=> PIVOT_ATTEN_DB == 4'hf && !PIVOT_RESERVED;
   endproperty
   a_pivot: assert property (p_pivot) else $error("pivot -15 dB decode"); // R13
   property p_rsv_mode;
      @(posedge CORE_CLK) disable iff (!RSTN)
      (plan_mode_r == 2'h3) |=> !OPT_MODE_ACTIVE;
   endproperty
   a_rsv_mode: assert property (p_rsv_mode) else $error("reserved mode not regular"); // R14
   // a write, three idle cycles, then a read of the same register
   property p_readback;
      logic [3:0] wv;
      @(posedge CORE_CLK) disable iff (!RSTN)
      (s_plan_write, wv = REG_WDATA[3:0]) ##1 (!REG_WR)[*3] ##1 s_plan_read
         |=> REG_RDATA == {4'h0, wv};
   endproperty
   a_readback: assert property (p_readback) else $error("rate plan readback"); // R15

endmodule : mas_scheduler

`default_nettype wire

// ---- mas_scheduler_tb.sv ----
//
// Purpose : self-checking bench for the measurement converter scheduler
// Assumes : inputs driven on the falling edge, short fixed thermal period
// Notes   : sample periods are measured between consecutive strobes
//
`timescale 1ns/1ps
`default_nettype none

module mas_scheduler_tb;
   import mas_pkg::*;

   logic        core_clk, rstn, reg_wr, reg_rd, active, bsel, tvalid, svalid;
   logic [15:0] reg_addr;
   logic [7:0]  reg_wdata, reg_rdata;
   logic [2:0]  auto_req, ch_enable;
   logic [8:0]  temp_code, src_sample, src_avg;
   logic [3:0]  strobe, atten;
   logic [9:0]  peak_c;
   logic        avg_valid, piv_rsv, opt_act;
   int          fail_count = 0;
   int          n_checks   = 0;

   mas_scheduler #(.THERM_OPT_CYC(16'h0014)) uut (
      .CORE_CLK(core_clk), .RSTN(rstn), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
      .REG_RD(reg_rd), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .ACTIVE(active),
      .BROWNOUT_SOURCE_SELECT(bsel), .CH_AUTO_REQ(auto_req),
      .POWER_RATE_CYC(16'h0032), .BATTERY_RATE_CYC(16'h003c),
      .HIGH_RATE_CYC(16'h0046), .THERM_RATE_CYC(16'h0050),
      .TEMP_CODE(temp_code), .TEMP_CODE_VALID(tvalid), .SRC_SAMPLE(src_sample),
      .SRC_SAMPLE_VALID(svalid), .CH_ENABLE(ch_enable), .SAMPLE_STROBE(strobe),
      .PEAK_TEMP_C(peak_c), .SRC_AVG(src_avg), .SRC_AVG_VALID(avg_valid),
      .PIVOT_ATTEN_DB(atten), .PIVOT_RESERVED(piv_rsv), .OPT_MODE_ACTIVE(opt_act));

   // ****************************************************************
   // shared helpers
   // ****************************************************************
   task automatic end_of_test;
      if (fail_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : end_of_test

   task automatic chk(input logic ok, input string msg);
      n_checks++;
      if (ok !== 1'b1) begin
         fail_count++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask : chk

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      reg_addr = a; reg_wdata = d; reg_wr = 1'b1;
      @(negedge core_clk) reg_wr = 1'b0;
      repeat (3) @(negedge core_clk);
   endtask : wr

   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      reg_addr = a; reg_rd = 1'b1;
      @(negedge core_clk) reg_rd = 1'b0;
      @(negedge core_clk) chk(reg_rdata === e, "register readback");
   endtask : rd

   // counts falling edges up to the next strobe on one channel
   task automatic gap(input int idx, output int n);
      n = 0;
      do begin
         @(negedge core_clk);
         n++;
      end while (strobe[idx] !== 1'b1 && n < 8000);
   endtask : gap

   task automatic per(input int idx, input int e);
      int n;
      gap(idx, n);
      gap(idx, n);
      gap(idx, n);
      chk(n == e, "sample period");
   endtask : per

   task automatic src(input logic [8:0] v, input logic [8:0] e, input bit test);
      src_sample = v; svalid = 1'b1;
      @(negedge core_clk) svalid = 1'b0;
      // the strobe stands for this one cycle only; the average holds until the next sample
      chk(avg_valid === 1'b1 && (!test || src_avg === e), "source average");
      @(negedge core_clk);
   endtask : src

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_reset;
      chk(peak_c === 10'h304, "peak after reset");
      rd(MAS_PEAK_HIGH_ADDR, 8'h00);
      rd(MAS_PEAK_LOW_ADDR, 8'h00);
      rd(MAS_RATE_PLAN_ADDR, 8'h04);
      rd(MAS_CH_FORCE_ADDR, 8'h00);
      rd(MAS_PIVOT_ADDR, 8'h00);
      rd(16'h20c9, 8'h00);
   endtask : t_reset

   task automatic t_regs;
      wr(MAS_CH_FORCE_ADDR, 8'hff);
      rd(MAS_CH_FORCE_ADDR, 8'h07);
      wr(MAS_RATE_PLAN_ADDR, 8'hfb);
      rd(MAS_RATE_PLAN_ADDR, 8'h0b);
      wr(MAS_PEAK_HIGH_ADDR, 8'h5a);
      rd(MAS_PEAK_HIGH_ADDR, 8'h00);
   endtask : t_regs

   task automatic t_peak(input logic [8:0] c);
      temp_code = c; tvalid = 1'b1;
      @(negedge core_clk) tvalid = 1'b0;
      repeat (3) @(negedge core_clk);
   endtask : t_peak

   task automatic t_peaks;
      t_peak(9'h12c);
      chk(peak_c === 10'h030, "peak celsius");
      rd(MAS_PEAK_HIGH_ADDR, 8'h96);
      t_peak(9'h064);
      chk(peak_c === 10'h030, "lower code kept out");
      t_peak(9'h12d);
      rd(MAS_PEAK_LOW_ADDR, 8'h01);
      rd(MAS_PEAK_HIGH_ADDR, 8'h96);
      chk(peak_c === 10'h031, "peak low bit");
   endtask : t_peaks

   task automatic t_pivot;
      logic [3:0] e;
      for (int c = 0; c < 16; c++) begin
         e = (c <= 6) ? 4'(c) : (c == 7) ? 4'h8 : (c == 8) ? 4'ha :
             (c == 9) ? 4'hc : (c == 10) ? 4'hf : 4'h0;
         wr(MAS_PIVOT_ADDR, 8'(c));
         chk(atten === e && piv_rsv === (c > 10), "pivot decode");
         rd(MAS_PIVOT_ADDR, 8'(c));
      end
   endtask : t_pivot

   task automatic t_force;
      active = 1'b1; auto_req = 3'h0;
      for (int i = 0; i < 3; i++) begin
         wr(MAS_CH_FORCE_ADDR, 8'(1 << i));
         chk(ch_enable === 3'(1 << i), "channel force");
      end
      wr(MAS_CH_FORCE_ADDR, 8'h07);
      active = 1'b0;
      repeat (3) @(negedge core_clk);
      chk(ch_enable === 3'h0, "force outside active");
      wr(MAS_CH_FORCE_ADDR, 8'h00);
      active = 1'b1; auto_req = 3'h5;
      repeat (3) @(negedge core_clk);
      chk(ch_enable === 3'h5, "automatic enable");
      auto_req = 3'h0;
   endtask : t_force

   task automatic t_rates;
      wr(MAS_CH_FORCE_ADDR, 8'h07);
      wr(MAS_RATE_PLAN_ADDR, 8'h04);
      chk(opt_act === 1'b0, "regular mode flag");
      per(0, 50); per(1, 60); per(2, 70); per(3, 80);
      wr(MAS_RATE_PLAN_ADDR, 8'h05);
      chk(opt_act === 1'b1, "optimal mode flag");
      per(0, 333); per(1, 666); per(3, 20); per(2, 70);
      bsel = 1'b1;
      per(1, 333); per(0, 666);
      bsel = 1'b0;
      wr(MAS_RATE_PLAN_ADDR, 8'h06);
      per(0, 222); per(1, 2666); per(3, 20);
      wr(MAS_RATE_PLAN_ADDR, 8'h07);
      chk(opt_act === 1'b0, "reserved mode flag");
      per(0, 50);
   endtask : t_rates

   task automatic t_avg;
      wr(MAS_RATE_PLAN_ADDR, 8'h04);
      src(9'h04d, 9'h04d, 1'b1);
      wr(MAS_RATE_PLAN_ADDR, 8'h0d);
      src(9'h04d, 9'h04d, 1'b1);
      wr(MAS_RATE_PLAN_ADDR, 8'h01);
      src(9'h011, 9'h011, 1'b1);
      wr(MAS_RATE_PLAN_ADDR, 8'h05);
      src(9'h014, 9'h000, 1'b0);
      src(9'h014, 9'h000, 1'b0);
      src(9'h00a, 9'h00f, 1'b1);
      wr(MAS_RATE_PLAN_ADDR, 8'h09);
      repeat (4) src(9'h028, 9'h000, 1'b0);
      src(9'h000, 9'h01e, 1'b1);
      wr(MAS_RATE_PLAN_ADDR, 8'h07);
      src(9'h033, 9'h033, 1'b1);
   endtask : t_avg

   // ****************************************************************
   // clock, reset, sequence and watchdog
   // ****************************************************************
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   initial begin
      rstn = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 16'h0000;
      reg_wdata = 8'h00; active = 1'b0; bsel = 1'b0; auto_req = 3'h0;
      temp_code = 9'h000; tvalid = 1'b0; src_sample = 9'h000; svalid = 1'b0;
      repeat (2) @(negedge core_clk);
      rstn = 1'b1;
      @(negedge core_clk);
      t_reset;
      t_regs;
      t_peaks;
      t_pivot;
      t_force;
      t_rates;
      t_avg;
      end_of_test;
   end

   initial begin
      #200000;
      fail_count++;
      end_of_test;
   end

endmodule : mas_scheduler_tb

`default_nettype wire
